// ===== hw/mad_pkg.sv
// Purpose: Constants for the arithmetic, logic and move opcode decoder
// Assumes: 8-bit opcodes, machine-cycle enable from a divider
// Notes: Operation and addressing encodings shared with the bench
package mad_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned MC_NS = 120;
  localparam int unsigned MC_CYCLES = (MC_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] ACC_SFR_ADDR = 8'hE0;
  localparam logic [7:0] DIRECT_RAM_TOP = 8'h7F;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW,
    OP_LOGICAL_AND, OP_LOGICAL_OR, OP_LOGICAL_XOR,
    OP_ROTATE_LEFT, OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_RIGHT,
    OP_ROTATE_RIGHT_THRU_CARRY, OP_SWAP_NIBBLES, OP_MOVE,
    OP_LOAD_POINTER, OP_CODE_MEMORY_READ, OP_EXT_READ, OP_EXT_WRITE,
    OP_PUSH, OP_POP, OP_EXCHANGE, OP_EXCHANGE_LOW_NIBBLE
  } mad_op_e;

  typedef enum logic [3:0] {
    AM_NONE, AM_ACC, AM_REG, AM_DIRECT, AM_INDIRECT, AM_IMM, AM_IMM16,
    AM_CODE_DATA_POINTER_16, AM_CODE_PC, AM_EXT_IND8, AM_EXT_DATA_POINTER_16
  } mad_am_e;
endpackage

// ===== hw/mad_decoder.sv
// Operation
// - Add opcodes 2x, 25, 26/27, 24 decode, one machine cycle each.
// - Add-with-carry 3x, 35, 36/37, 34 decode, one machine cycle.
// - Subtract-with-borrow 9x, 95, 96/97, 94 decode, one machine cycle.
// - And 5x,55,56/57,54,52 one cycle; 53 three bytes two cycles.
// - Or 4x,45,46/47,44,42 one cycle; 43 three bytes two cycles.
// - Xor 6x,65,66/67,64,62 one cycle; 63 three bytes two cycles.
// - Rotates 23, 33, 03, 13 are one byte, one cycle.
// - C4 swaps accumulator nibbles, one byte, one cycle.
// - Accumulator loads Ex, E5, E6/E7, 74 take one cycle.
// - Accumulator stores Fx, F5, F6/F7 take one cycle.
// - Ax and 8x register/direct moves are two bytes, two cycles.
// - 85 copies direct to direct, three bytes, two cycles.
// - 75 three bytes two cycles; 7x, 76/77 two bytes one cycle.
// - 86/87 and A6/A7 indirect-direct moves are two bytes, two cycles.
// - 90 loads 16-bit data pointer, three bytes, two cycles.
// - 93 reads code at A+data_pointer_16, 83 at A+pc; one byte, two cycles.
// - External E2/E3, E0, F2/F3, F0 take two cycles.
// - Push C0 and pop D0 are two bytes, two cycles.
// - Exchange Cx, C5, C6/C7 take one cycle.
// - D6/D7 swap low nibbles with indirect RAM, one byte, one cycle.
// - Low nibble 8 to F selects working register 0 to 7.
// - Indirect forms use register 0 or 1, chosen by opcode bit 0.
// - Direct byte reaches lower 128 RAM bytes or any special register.
// - Sixteen-bit constant comes from instruction bytes two and three.
//
// Purpose: Decode and sequence ALU and move opcodes of an 8-bit core
// Assumes: Code bytes valid on code_data when code_valid is high
// Notes: Execution datapath lives outside; this block only steers it
`timescale 1ns/1ps
`default_nettype none
module mad_decoder #(
  parameter int unsigned MC_CYCLES = mad_pkg::MC_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] code_data,
  input wire logic code_valid,
  output logic fetch_req,
  output logic instr_done,
  output logic busy,
  output logic [7:0] opcode,
  output logic [7:0] operand1,
  output logic [7:0] operand2,
  output logic [15:0] imm16,
  output mad_pkg::mad_op_e op,
  output mad_pkg::mad_am_e src_mode,
  output mad_pkg::mad_am_e dst_mode,
  output logic [2:0] reg_sel,
  output logic use_carry,
  output logic direct_is_sfr,
  output logic illegal_acc_load,
  output logic [1:0] instr_len,
  output logic [1:0] instr_cycles
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode table

  typedef struct packed {
    mad_pkg::mad_op_e op;
    mad_pkg::mad_am_e src;
    mad_pkg::mad_am_e dst;
    logic [1:0] len;
    logic [1:0] cyc;
  } mad_dec_s;

  // Operand mode from low nibble of the common arithmetic pattern
  function automatic mad_pkg::mad_am_e mad_low_mode(input logic [3:0] lo);
    mad_low_mode = mad_pkg::AM_NONE;
    if (lo[3])
      mad_low_mode = mad_pkg::AM_REG;
    else if (lo[3:1] == 3'h3)
      mad_low_mode = mad_pkg::AM_INDIRECT;
    else if (lo == 4'h5)
      mad_low_mode = mad_pkg::AM_DIRECT;
    else if (lo == 4'h4)
      mad_low_mode = mad_pkg::AM_IMM;
  endfunction

  function automatic logic [1:0] mad_mode_len(input mad_pkg::mad_am_e m);
    mad_mode_len = (m == mad_pkg::AM_DIRECT || m == mad_pkg::AM_IMM) ?
      mad_pkg::LEN_TWO : mad_pkg::LEN_ONE;
  endfunction

  function automatic mad_dec_s mad_decode(input logic [7:0] oc);
    mad_dec_s d;
    mad_pkg::mad_am_e lm;
    d = '{mad_pkg::OP_NONE, mad_pkg::AM_NONE, mad_pkg::AM_NONE,
          mad_pkg::LEN_ONE, mad_pkg::CYC_ONE};
    lm = mad_low_mode(oc[3:0]);
    case (oc[7:4])
      4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6:
      begin
        if (lm != mad_pkg::AM_NONE)
        begin
          d.src = lm;
          d.dst = mad_pkg::AM_ACC;
          d.len = mad_mode_len(lm);
        end
      end
      4'hE:
      begin
        if (lm != mad_pkg::AM_NONE && lm != mad_pkg::AM_IMM)
          d = '{mad_pkg::OP_MOVE, lm, mad_pkg::AM_ACC, mad_mode_len(lm),
                mad_pkg::CYC_ONE};
      end
      4'hF:
      begin
        if (lm != mad_pkg::AM_NONE && lm != mad_pkg::AM_IMM)
          d = '{mad_pkg::OP_MOVE, mad_pkg::AM_ACC, lm, mad_mode_len(lm),
                mad_pkg::CYC_ONE};
      end
      4'hC:
      begin
        if (lm != mad_pkg::AM_NONE && lm != mad_pkg::AM_IMM)
          d = '{mad_pkg::OP_EXCHANGE, lm, mad_pkg::AM_ACC, mad_mode_len(lm),
                mad_pkg::CYC_ONE};
      end
      4'hA:
      begin
        if (oc[3] || oc[3:1] == 3'h3)
          d = '{mad_pkg::OP_MOVE, mad_pkg::AM_DIRECT, lm, mad_pkg::LEN_TWO,
                mad_pkg::CYC_TWO};
      end
      4'h8:
      begin
        if (oc[3] || oc[3:1] == 3'h3)
          d = '{mad_pkg::OP_MOVE, lm, mad_pkg::AM_DIRECT, mad_pkg::LEN_TWO,
                mad_pkg::CYC_TWO};
      end
      4'h7:
      begin
        if (oc[3] || oc[3:1] == 3'h3)
          d = '{mad_pkg::OP_MOVE, mad_pkg::AM_IMM, lm, mad_pkg::LEN_TWO,
                mad_pkg::CYC_ONE};
      end
      default:
        d.op = mad_pkg::OP_NONE;
    endcase
    case (oc[7:4])
      4'h2: if (d.src != mad_pkg::AM_NONE) d.op = mad_pkg::OP_ADD;
      4'h3: if (d.src != mad_pkg::AM_NONE) d.op = mad_pkg::OP_ADD_WITH_CARRY;
      4'h9: if (d.src != mad_pkg::AM_NONE) d.op = mad_pkg::OP_SUBTRACT_WITH_BORROW;
      4'h5: if (d.src != mad_pkg::AM_NONE) d.op = mad_pkg::OP_LOGICAL_AND;
      4'h4: if (d.src != mad_pkg::AM_NONE) d.op = mad_pkg::OP_LOGICAL_OR;
      4'h6: if (d.src != mad_pkg::AM_NONE) d.op = mad_pkg::OP_LOGICAL_XOR;
      default: d.op = d.op;
    endcase
    case (oc)
      8'h52, 8'h42, 8'h62:
      begin
        d.src = mad_pkg::AM_ACC;
        d.dst = mad_pkg::AM_DIRECT;
        d.len = mad_pkg::LEN_TWO;
        d.op = (oc[6:4] == 3'h5) ? mad_pkg::OP_LOGICAL_AND :
          (oc[6:4] == 3'h4) ? mad_pkg::OP_LOGICAL_OR : mad_pkg::OP_LOGICAL_XOR;
      end
      8'h53, 8'h43, 8'h63:
      begin
        d.src = mad_pkg::AM_IMM;
        d.dst = mad_pkg::AM_DIRECT;
        d.len = mad_pkg::LEN_THREE;
        d.cyc = mad_pkg::CYC_TWO;
        d.op = (oc[6:4] == 3'h5) ? mad_pkg::OP_LOGICAL_AND :
          (oc[6:4] == 3'h4) ? mad_pkg::OP_LOGICAL_OR : mad_pkg::OP_LOGICAL_XOR;
      end
      8'h23: d = '{mad_pkg::OP_ROTATE_LEFT, mad_pkg::AM_ACC, mad_pkg::AM_ACC,
                   mad_pkg::LEN_ONE, mad_pkg::CYC_ONE};
      8'h33: d = '{mad_pkg::OP_ROTATE_LEFT_THRU_CARRY, mad_pkg::AM_ACC,
                   mad_pkg::AM_ACC, mad_pkg::LEN_ONE, mad_pkg::CYC_ONE};
      8'h03: d = '{mad_pkg::OP_ROTATE_RIGHT, mad_pkg::AM_ACC, mad_pkg::AM_ACC,
                   mad_pkg::LEN_ONE, mad_pkg::CYC_ONE};
      8'h13: d = '{mad_pkg::OP_ROTATE_RIGHT_THRU_CARRY, mad_pkg::AM_ACC,
                   mad_pkg::AM_ACC, mad_pkg::LEN_ONE, mad_pkg::CYC_ONE};
      8'hC4: d = '{mad_pkg::OP_SWAP_NIBBLES, mad_pkg::AM_ACC, mad_pkg::AM_ACC,
                   mad_pkg::LEN_ONE, mad_pkg::CYC_ONE};
      8'h74: d = '{mad_pkg::OP_MOVE, mad_pkg::AM_IMM, mad_pkg::AM_ACC,
                   mad_pkg::LEN_TWO, mad_pkg::CYC_ONE};
      8'h85: d = '{mad_pkg::OP_MOVE, mad_pkg::AM_DIRECT, mad_pkg::AM_DIRECT,
                   mad_pkg::LEN_THREE, mad_pkg::CYC_TWO};
      8'h75: d = '{mad_pkg::OP_MOVE, mad_pkg::AM_IMM, mad_pkg::AM_DIRECT,
                   mad_pkg::LEN_THREE, mad_pkg::CYC_TWO};
      8'h90: d = '{mad_pkg::OP_LOAD_POINTER, mad_pkg::AM_IMM16, mad_pkg::AM_NONE,
                   mad_pkg::LEN_THREE, mad_pkg::CYC_TWO};
      8'h93: d = '{mad_pkg::OP_CODE_MEMORY_READ, mad_pkg::AM_CODE_DATA_POINTER_16,
                   mad_pkg::AM_ACC, mad_pkg::LEN_ONE, mad_pkg::CYC_TWO};
      8'h83: d = '{mad_pkg::OP_CODE_MEMORY_READ, mad_pkg::AM_CODE_PC,
                   mad_pkg::AM_ACC, mad_pkg::LEN_ONE, mad_pkg::CYC_TWO};
      8'hE2, 8'hE3: d = '{mad_pkg::OP_EXT_READ, mad_pkg::AM_EXT_IND8,
                   mad_pkg::AM_ACC, mad_pkg::LEN_ONE, mad_pkg::CYC_TWO};
      8'hE0: d = '{mad_pkg::OP_EXT_READ, mad_pkg::AM_EXT_DATA_POINTER_16, mad_pkg::AM_ACC,
                   mad_pkg::LEN_ONE, mad_pkg::CYC_TWO};
      8'hF2, 8'hF3: d = '{mad_pkg::OP_EXT_WRITE, mad_pkg::AM_ACC,
                   mad_pkg::AM_EXT_IND8, mad_pkg::LEN_ONE, mad_pkg::CYC_TWO};
      8'hF0: d = '{mad_pkg::OP_EXT_WRITE, mad_pkg::AM_ACC, mad_pkg::AM_EXT_DATA_POINTER_16,
                   mad_pkg::LEN_ONE, mad_pkg::CYC_TWO};
      8'hC0: d = '{mad_pkg::OP_PUSH, mad_pkg::AM_DIRECT, mad_pkg::AM_NONE,
                   mad_pkg::LEN_TWO, mad_pkg::CYC_TWO};
      8'hD0: d = '{mad_pkg::OP_POP, mad_pkg::AM_NONE, mad_pkg::AM_DIRECT,
                   mad_pkg::LEN_TWO, mad_pkg::CYC_TWO};
      8'hD6, 8'hD7: d = '{mad_pkg::OP_EXCHANGE_LOW_NIBBLE, mad_pkg::AM_INDIRECT,
                   mad_pkg::AM_ACC, mad_pkg::LEN_ONE, mad_pkg::CYC_ONE};
      default: d.len = d.len;
    endcase
    mad_decode = d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Machine-cycle enable

  logic [7:0] mc_cnt_r;
  logic [7:0] mc_cnt_nxt;
  logic mc_tick;

  always_comb
  begin
    mc_tick = (mc_cnt_r == 8'(MC_CYCLES - 1));
    mc_cnt_nxt = mc_tick ? 8'h00 : mc_cnt_r + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      mc_cnt_r <= 8'h00;
    else
      mc_cnt_r <= mc_cnt_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  typedef enum {ST_FETCH, ST_OPERAND, ST_WAIT} mad_state_e;

  mad_state_e state_r;
  mad_state_e state_nxt;
  logic [1:0] got_r;
  logic [1:0] got_nxt;
  logic [1:0] mc_left_r;
  logic [1:0] mc_left_nxt;
  logic [7:0] opcode_nxt;
  logic [7:0] operand1_nxt;
  logic [7:0] operand2_nxt;
  logic done_nxt;
  mad_dec_s dec_r;
  mad_dec_s dec_nxt;
  mad_dec_s dec_in;

  always_comb
  begin
    dec_in = mad_decode(code_data);
    state_nxt = state_r;
    got_nxt = got_r;
    mc_left_nxt = mc_left_r;
    opcode_nxt = opcode;
    operand1_nxt = operand1;
    operand2_nxt = operand2;
    dec_nxt = dec_r;
    done_nxt = 1'b0;
    if (mc_tick && mc_left_r != 2'h0)
      mc_left_nxt = mc_left_r - 2'h1;
    case (state_r)
      ST_FETCH:
      begin
        if (code_valid)
        begin
          opcode_nxt = code_data;
          dec_nxt = dec_in;
          mc_left_nxt = dec_in.cyc;
          got_nxt = mad_pkg::LEN_ONE;
          state_nxt = (dec_in.len == mad_pkg::LEN_ONE) ? ST_WAIT : ST_OPERAND;
        end
      end
      ST_OPERAND:
      begin
        if (code_valid)
        begin
          if (got_r == mad_pkg::LEN_ONE)
            operand1_nxt = code_data;
          else
            operand2_nxt = code_data;
          got_nxt = got_r + 2'h1;
          if (got_r + 2'h1 == dec_r.len)
            state_nxt = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (mc_left_nxt == 2'h0)
        begin
          done_nxt = 1'b1;
          state_nxt = ST_FETCH;
        end
      end
      default:
        state_nxt = ST_FETCH;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= ST_FETCH;
      got_r <= 2'h0;
      mc_left_r <= 2'h0;
      opcode <= 8'h00;
      operand1 <= 8'h00;
      operand2 <= 8'h00;
      dec_r <= '{mad_pkg::OP_NONE, mad_pkg::AM_NONE, mad_pkg::AM_NONE,
                 mad_pkg::LEN_ONE, mad_pkg::CYC_ONE};
      instr_done <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      got_r <= got_nxt;
      mc_left_r <= mc_left_nxt;
      opcode <= opcode_nxt;
      operand1 <= operand1_nxt;
      operand2 <= operand2_nxt;
      dec_r <= dec_nxt;
      instr_done <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign fetch_req = (state_r != ST_WAIT);
  assign busy = (state_r != ST_FETCH);
  assign op = dec_r.op;
  assign src_mode = dec_r.src;
  assign dst_mode = dec_r.dst;
  assign instr_len = dec_r.len;
  assign instr_cycles = dec_r.cyc;
  assign imm16 = {operand1, operand2};
  // Indirect forms pick register 0 or 1; register forms use low three bits
  assign reg_sel = (dec_r.src == mad_pkg::AM_INDIRECT || dec_r.dst == mad_pkg::AM_INDIRECT ||
                    dec_r.src == mad_pkg::AM_EXT_IND8 || dec_r.dst == mad_pkg::AM_EXT_IND8) ?
                   {2'h0, opcode[0]} : opcode[2:0];
  assign use_carry = (dec_r.op == mad_pkg::OP_ADD_WITH_CARRY) ||
                     (dec_r.op == mad_pkg::OP_SUBTRACT_WITH_BORROW);
  // Above the lower 128 bytes a direct address means a special register
  assign direct_is_sfr = (operand1 > mad_pkg::DIRECT_RAM_TOP);
  // Flagged, not blocked: software is expected never to issue this
  assign illegal_acc_load = (opcode == 8'hE5) && (operand1 == mad_pkg::ACC_SFR_ADDR) &&
                            (state_r == ST_WAIT);

endmodule // mad_decoder
`default_nettype wire

// ===== tb/mad_decoder_properties.sv
// Purpose: Port-level assertions for the opcode decoder
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into every decoder instance
`timescale 1ns/1ps
`default_nettype none
module mad_decoder_properties #(
  parameter int unsigned MC_CYCLES = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic code_valid,
  input wire logic fetch_req,
  input wire logic instr_done,
  input wire logic busy,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [15:0] imm16,
  input wire mad_pkg::mad_op_e op,
  input wire logic [2:0] reg_sel,
  input wire logic direct_is_sfr,
  input wire logic illegal_acc_load,
  input wire logic [1:0] instr_len,
  input wire logic [1:0] instr_cycles
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // Clocks since the opcode was taken; saturates so it never wraps
  logic [7:0] age_r;
  logic [7:0] age_nxt;
  always_comb
  begin
    if (fetch_req && code_valid && !busy)
      age_nxt = 8'h01;
    else
      age_nxt = (age_r == 8'hFF) ? age_r : age_r + 8'h01;
  end
  always_ff @(posedge clk)
  begin
    age_r <= reset ? 8'h00 : age_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  add_group_a: assert property (
    busy && (opcode[7:3] == 5'h05 || opcode[7:2] == 6'h09)
    |-> op == mad_pkg::OP_ADD && instr_cycles == mad_pkg::CYC_ONE)
    else $error("add group decode mismatch");
  three_byte_a: assert property (
    busy && opcode inside {8'h53, 8'h43, 8'h63, 8'h85, 8'h75, 8'h90}
    |-> instr_len == mad_pkg::LEN_THREE && instr_cycles == mad_pkg::CYC_TWO)
    else $error("three byte form mismatch");
  reg_select_a: assert property (
    busy && opcode[3] && !(opcode[7:4] inside {4'h0, 4'h1, 4'hB, 4'hD})
    |-> reg_sel == opcode[2:0])
    else $error("register select mismatch");
  ind_select_a: assert property (
    busy && opcode[3:1] == 3'h3 && op != mad_pkg::OP_NONE
    |-> reg_sel == {2'h0, opcode[0]})
    else $error("pointer register select mismatch");
  sfr_flag_a: assert property (
    busy && !fetch_req |-> direct_is_sfr == (operand1 > mad_pkg::DIRECT_RAM_TOP))
    else $error("direct space flag mismatch");
  imm_pair_a: assert property (
    busy && !fetch_req |-> imm16 == {operand1, operand2})
    else $error("constant byte order mismatch");
  acc_load_a: assert property (
    busy && !fetch_req && opcode == 8'hE5
    |-> illegal_acc_load == (operand1 == mad_pkg::ACC_SFR_ADDR))
    else $error("self load flag mismatch");
  done_fetch_a: assert property (
    instr_done |-> fetch_req && !busy)
    else $error("fetch not resumed after done");
  two_cycle_a: assert property (
    instr_done && instr_cycles == mad_pkg::CYC_TWO |-> age_r > MC_CYCLES)
    else $error("two cycle instruction ended early");
  done_bound_a: assert property (
    $rose(busy) |-> ##[1:100] instr_done)
    else $error("instruction never completed");
endmodule // mad_decoder_properties
bind mad_decoder mad_decoder_properties #(.MC_CYCLES(MC_CYCLES)) props_i (
  .clk, .reset, .code_valid, .fetch_req, .instr_done, .busy, .opcode, .operand1,
  .operand2, .imm16, .op, .reg_sel, .direct_is_sfr, .illegal_acc_load, .instr_len,
  .instr_cycles
);
`default_nettype wire

// ===== tb/mad_code_mem.sv
// Purpose: Program memory model feeding the opcode decoder
// Assumes: Bench queues bytes through put
// Notes: Idle data shows the inverse of the last byte taken
`timescale 1ns/1ps
`default_nettype none
module mad_code_mem (
  input wire logic clk,
  input wire logic fetch_req,
  input wire logic slow,
  output logic [7:0] code_data,
  output logic code_valid
);
  logic [7:0] q [$];
  int rd = 0;
  int off = 0;
  logic [7:0] last = 8'h00;
  logic ph = 1'b0;
  initial
  begin
    code_data = 8'h00;
    code_valid = 1'b0;
  end
  task put(input logic [7:0] v);
    q.push_back(v);
  endtask
  always @(posedge clk)
  begin
    if (code_valid && fetch_req)
    begin
      rd <= rd + 1;
      last <= code_data;
    end
  end
  // Offered byte held until taken; slow mode idles every other cycle
  always @(negedge clk)
  begin
    ph <= ~ph;
    if (!(code_valid && rd == off))
    begin
      if (rd < q.size() && !(slow && ph))
      begin
        code_valid <= 1'b1;
        code_data <= q[rd];
        off <= rd;
      end
      else
      begin
        code_valid <= 1'b0;
        code_data <= ~last;
      end
    end
  end
endmodule // mad_code_mem
`default_nettype wire

// ===== tb/mad_decoder_tb_top.sv
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Short machine cycle through MC_CYCLES
// Notes: Table entry is opcode, length, cycles, operation code
`timescale 1ns/1ps
`default_nettype none
module mad_decoder_tb_top;
  localparam int unsigned MC = 8;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic slow = 1'b0;
  logic [7:0] code_data, opcode, operand1, operand2;
  logic code_valid, fetch_req, instr_done, busy, use_carry, direct_is_sfr, illegal_acc_load;
  logic [15:0] imm16;
  mad_pkg::mad_op_e op;
  mad_pkg::mad_am_e src_mode, dst_mode;
  logic [2:0] reg_sel;
  logic [1:0] instr_len, instr_cycles;
  int mismatches = 0;
  int n_checks = 0;
  int t_cnt;
  logic ill;
  logic [23:0] tbl [$] = {
    24'h281101, 24'h252101, 24'h261101, 24'h242101, 24'h3F1102, 24'h352102, 24'h371102,
    24'h342102, 24'h991103, 24'h952103, 24'h961103, 24'h942103, 24'h5A1104, 24'h552104,
    24'h571104, 24'h542104, 24'h522104, 24'h533204, 24'h4C1105, 24'h452105, 24'h461105,
    24'h442105, 24'h422105, 24'h433205, 24'h6F1106, 24'h652106, 24'h671106, 24'h642106,
    24'h622106, 24'h633206, 24'h231107, 24'h331108, 24'h031109, 24'h13110A, 24'hC4110B,
    24'hE8110C, 24'hE5210C, 24'hE6110C, 24'h74210C, 24'hF9110C, 24'hF5210C, 24'hF7110C,
    24'hAD220C, 24'h8E220C, 24'h85320C, 24'h75320C, 24'h7B210C, 24'h76210C, 24'h87220C,
    24'hA6220C, 24'h90320D, 24'h93120E, 24'h83120E, 24'hE3120F, 24'hE0120F, 24'hF21210,
    24'hF01210, 24'hC02211, 24'hD02212, 24'hCB1113, 24'hC52113, 24'hC71113, 24'hD61114,
    24'h041100};
  mad_decoder #(.MC_CYCLES(MC)) dut (.clk, .reset, .code_data, .code_valid, .fetch_req,
    .instr_done, .busy, .opcode, .operand1, .operand2, .imm16, .op, .src_mode, .dst_mode,
    .reg_sel, .use_carry, .direct_is_sfr, .illegal_acc_load, .instr_len, .instr_cycles);
  mad_code_mem mem_i (.clk, .fetch_req, .slow, .code_data, .code_valid);
  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("mismatches %0d n_checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wait_done;
    int k;
    t_cnt = 0;
    ill = 1'bx;
    for (k = 0; k < 400; k++)
    begin
      @(negedge clk);
      if (busy === 1'b1)
        t_cnt++;
      if (busy === 1'b1 && fetch_req === 1'b0)
        ill = illegal_acc_load;
      if (instr_done === 1'b1)
        break;
    end
    chk("done_seen", k < 400, 1'b1);
  endtask
  task run(input logic [23:0] e, input logic [7:0] a, input logic [7:0] b);
    int r0;
    int lo;
    int hi;
    @(posedge clk);
    r0 = mem_i.rd;
    mem_i.put(e[23:16]);
    if (e[15:12] > 4'h1)
      mem_i.put(a);
    if (e[15:12] > 4'h2)
      mem_i.put(b);
    wait_done();
    // Free-running ticks make the first machine cycle partial
    lo = (e[11:8] - 1) * MC + 1;
    hi = e[11:8] * MC + e[15:12] * 2 + 3;
    chk("fetched", mem_i.rd - r0, e[15:12]);
    chk("opcode", opcode, e[23:16]);
    if (e[15:12] > 4'h1)
      chk("opnd1", operand1, a);
    if (e[15:12] > 4'h2)
      chk("opnd2", operand2, b);
    chk("in_time", t_cnt >= lo && t_cnt <= hi, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_table;
    mad_pkg::mad_op_e x;
    logic cy;
    foreach (tbl[i])
    begin
      x = mad_pkg::mad_op_e'(tbl[i][4:0]);
      cy = (x == mad_pkg::OP_ADD_WITH_CARRY) || (x == mad_pkg::OP_SUBTRACT_WITH_BORROW);
      run(tbl[i], 8'h3C, 8'hA5);
      chk("op", op, x);
      chk("len", instr_len, tbl[i][13:12]);
      chk("cyc", instr_cycles, tbl[i][9:8]);
      chk("carry", use_carry, cy);
    end
  endtask
  task t_regs;
    run(24'h2D1101, 8'h00, 8'h00);
    chk("rsel", reg_sel, 3'h5);
    chk("rsrc", src_mode, mad_pkg::AM_REG);
    run(24'hE7110C, 8'h00, 8'h00);
    chk("isel", reg_sel, 3'h1);
    chk("isrc", src_mode, mad_pkg::AM_INDIRECT);
    run(24'hF6110C, 8'h00, 8'h00);
    chk("isel0", reg_sel, 3'h0);
    chk("idst", dst_mode, mad_pkg::AM_INDIRECT);
  endtask
  task t_direct;
    run(24'hE5210C, 8'h80, 8'h00);
    chk("sfr_hi", direct_is_sfr, 1'b1);
    chk("dsrc", src_mode, mad_pkg::AM_DIRECT);
    chk("ill_no", ill, 1'b0);
    run(24'h952103, 8'h7F, 8'h00);
    chk("sfr_lo", direct_is_sfr, 1'b0);
    run(24'hE5210C, mad_pkg::ACC_SFR_ADDR, 8'h00);
    chk("ill_yes", ill, 1'b1);
  endtask
  task t_b2b;
    int r0;
    @(posedge clk);
    slow = 1'b1;
    r0 = mem_i.rd;
    mem_i.put(8'h90);
    mem_i.put(8'h12);
    mem_i.put(8'h34);
    mem_i.put(8'hC4);
    wait_done();
    chk("b2b_fetch", mem_i.rd - r0, 3);
    chk("imm16", imm16, 16'h1234);
    chk("imm_src", src_mode, mad_pkg::AM_IMM16);
    wait_done();
    chk("b2b_op", op, mad_pkg::OP_SWAP_NIBBLES);
  endtask
  task t_reset;
    @(posedge clk);
    slow = 1'b0;
    mem_i.put(8'h53);
    repeat (4) @(negedge clk);
    chk("mid_busy", busy, 1'b1);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    chk("rst_fetch", fetch_req, 1'b1);
    chk("rst_busy", busy, 1'b0);
    chk("rst_op", op, mad_pkg::OP_NONE);
    chk("rst_len", instr_len, mad_pkg::LEN_ONE);
    reset = 1'b0;
    run(24'hC4110B, 8'h00, 8'h00);
    chk("post_op", op, mad_pkg::OP_SWAP_NIBBLES);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    t_table();
    t_regs();
    t_direct();
    t_b2b();
    t_reset();
    wrap_up();
  end
endmodule // mad_decoder_tb_top
`default_nettype wire
